// *** serial_peer.sv ***
// remote serial device model facing the port's pins
// assumes 16 system clocks per bit, 8 data bits, no parity
`timescale 1ns/10ps
`default_nettype none
module serial_peer (
   // clock
   input  wire logic clock,
   // line
   input  wire logic line_in,
   output logic      line_out,
   // capture
   output logic [7:0] got,
   output int         frames
);
   initial begin
      line_out = 1'b1;
      got = 8'h00;
      frames = 0;
   end
   // capture frames mid-bit, lsb first
   always begin
      @(negedge line_in);
      repeat (8) @(negedge clock);
      for (int i = 0; i < 8; i++) begin
         repeat (16) @(negedge clock);
         got[i] = line_in;
      end
      repeat (16) @(negedge clock);
      if (line_in === 1'b1) frames++;
   end
   // one frame, stop level chosen by caller; idle line pulled high
   task automatic send(input logic [7:0] b, input logic stop);
      logic [9:0] f;
      f = {stop, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         line_out = f[i];
         repeat (16) @(negedge clock);
      end
      line_out = 1'b1;
      repeat (16) @(negedge clock);
   endtask
   // short low pulse on the line
   task automatic glitch(input int n);
      line_out = 1'b0;
      repeat (n) @(negedge clock);
      line_out = 1'b1;
   endtask
endmodule
`default_nettype wire

// *** serial_port_core.sv ***
// asynchronous serial port with fifos, interrupts and infrared coder
// assumes synchronous inputs on clock, software drives config ports
//
// Operation
// - two sixteen-entry fifos; receive entries carry four status bits.
// - enabled port sends frames from transmit fifo until it empties.
// - busy rises with non-empty fifo, falls after last stop bit.
// - start bit rechecked on eighth tick; high line means false start.
// - data bits sampled every sixteenth tick, then parity checked.
// - low stop sample flags framing error; word stored with errors.
// - infrared zero is 3/16 bit high pulse; low input means zero.
// - low-power infrared pulse lasts three low-power reference ticks.
// - read gives 8 data plus 4 error bits; write queues 8 bits.
// - fifos are one entry deep until fifo enable is set.
// - empty and full flags per fifo; overrun in receive status.
// - per-fifo trigger level 1/8 to 7/8, half after reset.
// - events for overrun, break, parity, framing, timeout, levels.
// - enabled events ored onto one request; masked status shown.
// - mask bit one passes event; raw status always visible.
// - clear write of one clears event; zero does nothing.
// - timeout after 32 idle bit periods; cleared by empty or clear.
// - loopback feeds transmit line back into receiver.
// - 16.6 fractional divisor makes 16x tick, divided for bits.
// - divisors and line control latch together on line control write.
// - frame is start, data lsb first, optional parity, stop bits.
// - disabling port lets current character finish.
`include "serial_port_defs.svh"
`timescale 1ns/10ps
`default_nettype none

module serial_port_core #(
   parameter int DEPTH = `FIFO_DEPTH
) (
   // clock and reset
   input  wire logic        clock,
   input  wire logic        rst_n,
   // configuration
   input  wire logic        port_enable_bit,
   input  wire logic        loopback_enable_bit,
   input  wire logic        sir_enable,
   input  wire logic        sir_lowpower,
   input  wire logic [7:0]  ir_lp_divisor,
   input  wire logic [15:0] int_divisor_field,
   input  wire logic [5:0]  frac_divisor_field,
   input  wire logic [7:0]  line_control_reg,
   input  wire logic        line_control_write,
   input  wire logic [5:0]  fifo_level_select_reg,
   input  wire logic [10:0] irq_mask_reg,
   input  wire logic [10:0] irq_clear_reg,
   input  wire logic        irq_clear_write,
   input  wire logic        rx_error_clear,
   // transmit data
   input  wire logic [7:0]  tx_data,
   input  wire logic        tx_valid,
   output logic             tx_ready,
   // receive data
   output logic [11:0]      rx_data,
   output logic             rx_valid,
   input  wire logic        rx_ready,
   // status
   output logic             tx_busy,
   output logic             tx_fifo_empty_flag,
   output logic             tx_fifo_full_flag,
   output logic             rx_fifo_empty_flag,
   output logic             rx_fifo_full_flag,
   output logic [3:0]       rx_status_reg,
   output logic [10:0]      raw_irq_status_reg,
   output logic [10:0]      masked_irq_status_reg,
   output logic             irq,
   // serial pins
   input  wire logic        serial_rx_pin,
   output logic             serial_tx_pin
);
   import serial_port_pkg::*;

   localparam int AW = $clog2(DEPTH);
   localparam int CW = AW + 1;
   localparam int TW = $clog2(`RX_TIMEOUT_TICKS);

   function automatic logic [CW-1:0] level_of(input logic [2:0] sel);
      unique case (sel)
         3'h0:    level_of = CW'(DEPTH / 8);
         3'h1:    level_of = CW'(DEPTH / 4);
         3'h3:    level_of = CW'(DEPTH * 3 / 4);
         3'h4:    level_of = CW'(DEPTH * 7 / 8);
         default: level_of = CW'(DEPTH / 2);
      endcase
   endfunction

   function automatic logic par_bit(input logic [7:0] d, input logic [1:0] wl,
                                    input logic eps, input logic sps);
      logic [7:0] m;
      m = d & (8'hff >> (2'h3 - wl));
      if (sps) par_bit = ~eps;
      else par_bit = eps ? ^m : ~^m;
   endfunction

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   // latched configuration
   logic [15:0] cfg_int;
   logic [5:0]  cfg_frac;
   logic [7:0]  cfg_lcr;
   logic        cfg_fen;
   logic [1:0]  cfg_wlen;
   logic [2:0]  last_idx;
   logic [CW-1:0] fifo_limit;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cfg_int  <= 16'h0000;
         cfg_frac <= 6'h00;
         cfg_lcr  <= `LCR_RESET;
      end else if (line_control_write) begin
         cfg_int  <= int_divisor_field;
         cfg_frac <= frac_divisor_field;
         cfg_lcr  <= line_control_reg;
      end
   end
   assign cfg_fen    = cfg_lcr[`LCR_FEN];
   assign cfg_wlen   = cfg_lcr[`LCR_WLEN_HI:`LCR_WLEN_LO];
   assign last_idx   = 3'h4 + {1'b0, cfg_wlen};
   assign fifo_limit = cfg_fen ? CW'(DEPTH) : CW'(1);

   // 16x baud and low-power references
   logic        baud_x16_tick;
   logic [15:0] baud_cnt;
   logic [5:0]  frac_acc;
   logic [6:0]  frac_sum;
   logic        lowpower_ir_x16_tick;
   logic [7:0]  lp_cnt;
   assign frac_sum = {1'b0, frac_acc} + {1'b0, cfg_frac};
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         baud_x16_tick <= 1'b0;
         baud_cnt      <= 16'h0000;
         frac_acc      <= 6'h00;
      end else begin
         baud_x16_tick <= 1'b0;
         if (cfg_int == 16'h0000) begin
            baud_cnt <= 16'h0000;
         end else if (baud_cnt == 16'h0000) begin
            baud_x16_tick <= 1'b1;
            baud_cnt      <= cfg_int - 16'h0001 + {15'h0000, frac_sum[6]};
            frac_acc      <= frac_sum[5:0];
         end else begin
            baud_cnt <= baud_cnt - 16'h0001;
         end
      end
   end
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         lowpower_ir_x16_tick <= 1'b0;
         lp_cnt               <= 8'h00;
      end else begin
         lowpower_ir_x16_tick <= (lp_cnt == 8'h00);
         lp_cnt <= (lp_cnt == 8'h00) ? ir_lp_divisor - 8'h01 : lp_cnt - 8'h01;
      end
   end

   // transmit fifo
   logic [7:0]    tx_mem [DEPTH];
   logic [AW-1:0] tx_wptr, tx_rptr;
   logic [CW-1:0] tx_count, next_tx_count;
   logic          tx_push, tx_pop;
   tx_state_e     tx_state;
   assign tx_push = tx_valid && tx_ready;
   assign tx_pop  = baud_x16_tick && tx_state == TX_IDLE && tx_count != '0
                    && port_enable_bit;
   assign next_tx_count = tx_count + CW'(tx_push) - CW'(tx_pop);
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         tx_wptr  <= '0;
         tx_rptr  <= '0;
         tx_count <= '0;
         tx_ready <= 1'b0;
      end else begin
         if (tx_push) tx_mem[tx_wptr] <= tx_data;
         tx_wptr  <= tx_wptr + AW'(tx_push);
         tx_rptr  <= tx_rptr + AW'(tx_pop);
         tx_count <= next_tx_count;
         tx_ready <= next_tx_count < fifo_limit;
      end
   end

   // transmitter
   logic [3:0] tx_sub;
   logic [7:0] tx_shift;
   logic [2:0] tx_idx;
   logic       tx_line;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         tx_state <= TX_IDLE;
         tx_sub   <= 4'h0;
         tx_shift <= 8'h00;
         tx_idx   <= 3'h0;
         tx_line  <= 1'b1;
      end else if (baud_x16_tick) begin
         tx_sub <= tx_sub + 4'h1;
         unique case (tx_state)
            TX_IDLE: begin
               tx_sub <= 4'h0;
               if (tx_pop) begin
                  tx_state <= TX_START;
                  tx_shift <= tx_mem[tx_rptr];
                  tx_line  <= 1'b0;
               end
            end
            TX_START: if (tx_sub == `LAST_TICK) begin
               tx_state <= TX_DATA;
               tx_idx   <= 3'h0;
               tx_line  <= tx_shift[0];
            end
            TX_DATA: if (tx_sub == `LAST_TICK) begin
               if (tx_idx == last_idx) begin
                  tx_state <= cfg_lcr[`LCR_PEN] ? TX_PARITY : TX_STOP1;
                  tx_line  <= cfg_lcr[`LCR_PEN] ? par_bit(tx_shift, cfg_wlen,
                              cfg_lcr[`LCR_EPS], cfg_lcr[`LCR_SPS]) : 1'b1;
               end else begin
                  tx_idx  <= tx_idx + 3'h1;
                  tx_line <= tx_shift[tx_idx + 3'h1];
               end
            end
            TX_PARITY: if (tx_sub == `LAST_TICK) begin
               tx_state <= TX_STOP1;
               tx_line  <= 1'b1;
            end
            TX_STOP1: if (tx_sub == `LAST_TICK) begin
               tx_state <= cfg_lcr[`LCR_STP2] ? TX_STOP2 : TX_IDLE;
            end
            TX_STOP2: if (tx_sub == `LAST_TICK) tx_state <= TX_IDLE;
         endcase
      end
   end

   // infrared encoder and pin
   logic [1:0] lp_left;
   logic       ir_pulse;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         lp_left <= 2'h0;
      end else if (baud_x16_tick && tx_sub == 4'h0 && !tx_line) begin
         lp_left <= `IR_LP_PULSE;
      end else if (lowpower_ir_x16_tick && lp_left != 2'h0) begin
         lp_left <= lp_left - 2'h1;
      end
   end
   assign ir_pulse = sir_lowpower ? lp_left != 2'h0
                                  : !tx_line && tx_sub < `IR_PULSE_TICKS;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) serial_tx_pin <= 1'b1;
      else serial_tx_pin <= sir_enable ? ir_pulse : tx_line && !cfg_lcr[`LCR_BRK];
   end

   // receive source, decoder and loopback
   logic [3:0] ir_hold;
   logic       rx_src, rx_line, rx_prev;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) ir_hold <= 4'h0;
      else if (!serial_rx_pin) ir_hold <= `IR_HOLD_TICKS;
      else if (baud_x16_tick && ir_hold != 4'h0) ir_hold <= ir_hold - 4'h1;
   end
   assign rx_src = loopback_enable_bit ? tx_line
                 : sir_enable ? serial_rx_pin && ir_hold == 4'h0 : serial_rx_pin;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rx_line <= 1'b1;
         rx_prev <= 1'b1;
      end else begin
         rx_line <= rx_src;
         rx_prev <= rx_line;
      end
   end
   chk_loopback_path: assert property (
      loopback_enable_bit |=> rx_line == $past(tx_line)) else $error("loopback not routed");

   // receiver
   rx_state_e     rx_state;
   logic [3:0]    rx_sub;
   logic [7:0]    rx_shift;
   logic [2:0]    rx_idx;
   logic          rx_par, rx_done, rx_push, rx_over, oe_pend;
   logic [CW-1:0] rx_count, next_rx_count;
   logic [`WORD_W-1:0] rx_word;
   assign rx_done = baud_x16_tick && rx_state == RX_STOP && rx_sub == `LAST_TICK;
   assign rx_push = rx_done && rx_count < fifo_limit;
   assign rx_over = rx_done && rx_count >= fifo_limit;
   assign rx_word[7:0] = rx_shift;
   assign rx_word[`WORD_FE] = !rx_line;
   assign rx_word[`WORD_PE] = cfg_lcr[`LCR_PEN] && rx_par != par_bit(rx_shift,
                              cfg_wlen, cfg_lcr[`LCR_EPS], cfg_lcr[`LCR_SPS]);
   assign rx_word[`WORD_BE] = rx_shift == 8'h00 && !rx_line
                              && !(cfg_lcr[`LCR_PEN] && rx_par);
   assign rx_word[`WORD_OE] = oe_pend;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rx_state <= RX_IDLE;
         rx_sub   <= 4'h0;
         rx_shift <= 8'h00;
         rx_idx   <= 3'h0;
         rx_par   <= 1'b0;
      end else if (rx_state == RX_IDLE) begin
         rx_sub <= 4'h0;
         if (port_enable_bit && rx_prev && !rx_line) begin
            rx_state <= RX_START;
            rx_shift <= 8'h00;
         end
      end else if (baud_x16_tick) begin
         rx_sub <= rx_sub + 4'h1;
         unique case (rx_state)
            RX_START: if (rx_sub == `START_CHECK_TICK) begin
               rx_state <= rx_line ? RX_IDLE : RX_DATA;
               rx_sub   <= 4'h0;
               rx_idx   <= 3'h0;
            end
            RX_DATA: if (rx_sub == `LAST_TICK) begin
               rx_shift[rx_idx] <= rx_line;
               rx_idx <= rx_idx + 3'h1;
               if (rx_idx == last_idx)
                  rx_state <= cfg_lcr[`LCR_PEN] ? RX_PARITY : RX_STOP;
            end
            RX_PARITY: if (rx_sub == `LAST_TICK) begin
               rx_par   <= rx_line;
               rx_state <= RX_STOP;
            end
            default: if (rx_sub == `LAST_TICK) rx_state <= RX_IDLE;
         endcase
      end
   end
   chk_false_start: assert property (
      rx_state == RX_START && baud_x16_tick && rx_sub == `START_CHECK_TICK && rx_line
      |=> rx_state == RX_IDLE) else $error("false start accepted");
   chk_sample_spacing: assert property (
      rx_state == RX_DATA && baud_x16_tick && rx_sub == `LAST_TICK && rx_idx != last_idx
      |=> rx_state == RX_DATA && rx_sub == 4'h0 && rx_idx == $past(rx_idx) + 3'h1)
      else $error("data sample spacing");

   // receive fifo
   logic [`WORD_W-1:0] rx_mem [DEPTH];
   logic [AW-1:0]      rx_wptr, rx_rptr;
   logic               rx_pop, out_fire;
   logic [1:0]         buf_cnt, next_buf_cnt;
   logic [`WORD_W-1:0] buf1;
   assign out_fire = rx_valid && rx_ready;
   assign rx_pop   = rx_count != '0 && buf_cnt != 2'h2;
   assign next_rx_count = rx_count + CW'(rx_push) - CW'(rx_pop);
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rx_wptr  <= '0;
         rx_rptr  <= '0;
         rx_count <= '0;
         oe_pend  <= 1'b0;
      end else begin
         if (rx_push) rx_mem[rx_wptr] <= rx_word;
         rx_wptr  <= rx_wptr + AW'(rx_push);
         rx_rptr  <= rx_rptr + AW'(rx_pop);
         rx_count <= next_rx_count;
         oe_pend  <= rx_over || (oe_pend && !rx_push);
      end
   end
   chk_frame_error: assert property (
      rx_push |=> rx_mem[$past(rx_wptr)][`WORD_FE] == !$past(rx_line))
      else $error("framing error not stored");
   chk_holding_depth: assert property (
      !cfg_fen && rx_count == CW'(1) && !rx_pop && rx_done |=> rx_count == CW'(1))
      else $error("holding register overfilled");

   // two-entry output buffer
   assign next_buf_cnt = buf_cnt - 2'(out_fire) + 2'(rx_pop);
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         buf_cnt  <= 2'h0;
         buf1     <= '0;
         rx_data  <= '0;
         rx_valid <= 1'b0;
      end else begin
         if (out_fire && buf_cnt == 2'h2) rx_data <= buf1;
         else if (rx_pop && (buf_cnt == 2'h0 || out_fire)) rx_data <= rx_mem[rx_rptr];
         else if (rx_pop) buf1 <= rx_mem[rx_rptr];
         buf_cnt  <= next_buf_cnt;
         rx_valid <= next_buf_cnt != 2'h0;
      end
   end

   // flags and receive status
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         tx_busy            <= 1'b0;
         tx_fifo_empty_flag <= 1'b1;
         tx_fifo_full_flag  <= 1'b0;
         rx_fifo_empty_flag <= 1'b1;
         rx_fifo_full_flag  <= 1'b0;
         rx_status_reg      <= 4'h0;
      end else begin
         tx_busy            <= next_tx_count != '0 || tx_state != TX_IDLE || tx_pop;
         tx_fifo_empty_flag <= next_tx_count == '0;
         tx_fifo_full_flag  <= next_tx_count >= fifo_limit;
         rx_fifo_empty_flag <= next_rx_count == '0;
         rx_fifo_full_flag  <= next_rx_count >= fifo_limit;
         rx_status_reg <= (rx_error_clear ? 4'h0 : rx_status_reg)
            | (out_fire ? rx_data[`WORD_OE:`WORD_FE] : 4'h0)
            | {rx_over, 3'h0};
      end
   end
   chk_busy_rise: assert property (tx_push |=> tx_busy) else $error("busy late");
   chk_busy_hold: assert property (
      tx_state != TX_IDLE || tx_pop |=> tx_busy) else $error("busy dropped in frame");

   // receive timeout
   logic [TW-1:0] rt_cnt;
   logic          rt_hit;
   assign rt_hit = baud_x16_tick && rx_count != '0
                   && rt_cnt == TW'(`RX_TIMEOUT_TICKS - 1);
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) rt_cnt <= '0;
      else if (rx_push || rx_count == '0 || rt_hit) rt_cnt <= '0;
      else if (baud_x16_tick) rt_cnt <= rt_cnt + TW'(1);
   end

   // interrupt status
   logic [10:0] set_ev, clr_ev;
   always_comb begin
      set_ev = 11'h000;
      set_ev[`IRQ_RX] = rx_count >= level_of(fifo_level_select_reg[5:3]);
      set_ev[`IRQ_TX] = tx_count <= level_of(fifo_level_select_reg[2:0]);
      set_ev[`IRQ_RT] = rt_hit;
      set_ev[`IRQ_FE] = rx_push && rx_word[`WORD_FE];
      set_ev[`IRQ_PE] = rx_push && rx_word[`WORD_PE];
      set_ev[`IRQ_BE] = rx_push && rx_word[`WORD_BE];
      set_ev[`IRQ_OE] = rx_over;
      clr_ev = irq_clear_write ? irq_clear_reg : 11'h000;
      clr_ev[`IRQ_RT] = clr_ev[`IRQ_RT] || rx_count == '0;
   end
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         raw_irq_status_reg    <= 11'h000;
         masked_irq_status_reg <= 11'h000;
         irq                   <= 1'b0;
      end else begin
         raw_irq_status_reg    <= (raw_irq_status_reg & ~clr_ev) | set_ev;
         masked_irq_status_reg <= raw_irq_status_reg & irq_mask_reg;
         irq                   <= |(raw_irq_status_reg & irq_mask_reg);
      end
   end
   chk_irq_or: assert property (
      irq == |masked_irq_status_reg) else $error("irq not or of masked");
   chk_mask_gate: assert property (
      ##1 (masked_irq_status_reg & ~$past(irq_mask_reg)) == 11'h000)
      else $error("masked event leaked");
   chk_clear_w1c: assert property (
      irq_clear_write && (irq_clear_reg & set_ev) == 11'h000
      |=> (raw_irq_status_reg & $past(irq_clear_reg)) == 11'h000) else $error("clear ignored");
   chk_timeout_empty: assert property (
      rx_count == '0 |=> !raw_irq_status_reg[`IRQ_RT]) else $error("timeout with empty fifo");

   cov_frame_sent: cover property (tx_state == TX_STOP1 ##1 tx_state == TX_IDLE);
   cov_overrun: cover property (rx_over);
   cov_timeout: cover property (rt_hit);
   cov_buffer_full: cover property (buf_cnt == 2'h2 && !rx_ready);
endmodule

`default_nettype wire

// *** serial_port_core_tb_top.sv ***
// self-checking bench for the serial port core
// assumes divisor 1.0, so one bit lasts 16 system clocks
`timescale 1ns/10ps
`default_nettype none
module serial_port_core_tb_top;
   logic        clock, rst_n, port_enable_bit, loopback_enable_bit;
   logic        sir_enable, sir_lowpower, line_control_write, irq_clear_write;
   logic        rx_error_clear, tx_valid, tx_ready, rx_valid, rx_ready, tx_busy;
   logic        tx_fifo_empty_flag, tx_fifo_full_flag, rx_fifo_empty_flag;
   logic        rx_fifo_full_flag, irq, serial_rx_pin, serial_tx_pin;
   logic [7:0]  ir_lp_divisor, line_control_reg, tx_data, got;
   logic [15:0] int_divisor_field;
   logic [5:0]  frac_divisor_field, fifo_level_select_reg;
   logic [10:0] irq_mask_reg, irq_clear_reg, raw_irq_status_reg, masked_irq_status_reg;
   logic [11:0] rx_data;
   logic [3:0]  rx_status_reg;
   int          fails, checks_done, frames;

   serial_port_core DUT (.clock, .rst_n, .port_enable_bit, .loopback_enable_bit,
      .sir_enable, .sir_lowpower, .ir_lp_divisor, .int_divisor_field, .frac_divisor_field,
      .line_control_reg, .line_control_write, .fifo_level_select_reg, .irq_mask_reg,
      .irq_clear_reg, .irq_clear_write, .rx_error_clear, .tx_data, .tx_valid, .tx_ready,
      .rx_data, .rx_valid, .rx_ready, .tx_busy, .tx_fifo_empty_flag, .tx_fifo_full_flag,
      .rx_fifo_empty_flag, .rx_fifo_full_flag, .rx_status_reg, .raw_irq_status_reg,
      .masked_irq_status_reg, .irq, .serial_rx_pin, .serial_tx_pin);
   serial_peer peer (.clock, .line_in(serial_tx_pin), .line_out(serial_rx_pin), .got,
      .frames);

   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   task automatic end_sim;
      if (fails == 0 && checks_done > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input logic [11:0] g, input logic [11:0] e);
      checks_done++;
      if (g !== e) begin
         fails++;
         $display("[ERR] %0t got %h expected %h", $time, g, e);
      end
   endtask
   task automatic timeout;
      fails++;
      end_sim();
   endtask
   // divisors and line control latched together while the port is off
   task automatic cfg(input logic [7:0] lcr);
      port_enable_bit = 1'b0;
      int_divisor_field = 16'h0001;
      frac_divisor_field = 6'h00;
      line_control_reg = lcr;
      line_control_write = 1'b1;
      @(negedge clock);
      line_control_write = 1'b0;
   endtask
   // request held until ready seen, then one idle edge
   task automatic push(input logic [7:0] b);
      int n;
      n = 0;
      tx_data = b;
      tx_valid = 1'b1;
      while (tx_ready !== 1'b1) begin
         if (++n > 3000) timeout();
         @(negedge clock);
      end
      @(negedge clock);
      tx_valid = 1'b0;
      @(negedge clock);
   endtask
   task automatic pop(input logic [11:0] e);
      int n;
      n = 0;
      while (rx_valid !== 1'b1) begin
         if (++n > 3000) timeout();
         @(negedge clock);
      end
      chk(rx_data, e);
      rx_ready = 1'b1;
      @(negedge clock);
      rx_ready = 1'b0;
   endtask
   // busy must still stand when the last stop bit is seen, then fall
   task automatic drain(input int target);
      int n;
      n = 0;
      while (frames < target) begin
         if (++n > 9000) timeout();
         @(negedge clock);
      end
      chk(tx_busy, 1'b1);
      while (tx_busy !== 1'b0) begin
         if (++n > 9000) timeout();
         @(negedge clock);
      end
   endtask

   task automatic s_reset;
      chk({tx_fifo_empty_flag, tx_fifo_full_flag, rx_fifo_empty_flag}, 12'h005);
      chk({rx_fifo_full_flag, tx_busy, serial_tx_pin, irq}, 12'h002);
   endtask
   task automatic s_holding;
      cfg(8'h60);
      push(8'ha5);
      chk({tx_busy, tx_fifo_full_flag, tx_ready}, 12'h006);
      port_enable_bit = 1'b1;
      drain(1);
      chk(got, 12'h0a5);
   endtask
   task automatic s_fifo;
      cfg(8'h70);
      for (int i = 0; i < 16; i++) push(8'(i + 8'h40));
      chk({tx_fifo_full_flag, tx_ready}, 12'h002);
      port_enable_bit = 1'b1;
      drain(17);
      chk(got, 12'h04f);
   endtask
   // infrared send of a zero byte: nine 3-clock pulses, no reception
   task automatic s_infrared;
      int hi;
      hi = 0;
      sir_enable = 1'b1;
      push(8'h00);
      repeat (220) begin
         @(negedge clock);
         if (serial_tx_pin === 1'b1) hi++;
      end
      chk(12'(hi), 12'h01b);
      chk(tx_busy, 1'b0);
      sir_enable = 1'b0;
   endtask
   task automatic s_loop;
      loopback_enable_bit = 1'b1;
      push(8'h5a);
      pop(12'h05a);
      loopback_enable_bit = 1'b0;
   endtask
   task automatic s_false_start;
      peer.glitch(4);
      repeat (400) @(negedge clock);
      chk(rx_valid, 1'b0);
      peer.send(8'hc3, 1'b1);
      pop(12'h0c3);
   endtask
   task automatic s_frame_err;
      peer.send(8'h33, 1'b0);
      pop(12'h133);
      chk(rx_status_reg[0], 1'b1);
      chk({raw_irq_status_reg[7], irq}, 12'h002);
      irq_mask_reg = 11'h080;
      repeat (3) @(negedge clock);
      chk({masked_irq_status_reg[7], irq}, 12'h003);
      irq_clear_reg = 11'h080;
      irq_clear_write = 1'b1;
      @(negedge clock);
      irq_clear_write = 1'b0;
      repeat (3) @(negedge clock);
      chk({raw_irq_status_reg[7], irq}, 12'h000);
   endtask

   initial begin
      {rst_n, port_enable_bit, loopback_enable_bit, sir_enable, sir_lowpower} = 5'h00;
      {line_control_write, irq_clear_write, rx_error_clear, tx_valid, rx_ready} = 5'h00;
      {ir_lp_divisor, line_control_reg, tx_data, int_divisor_field} = 40'h0;
      {frac_divisor_field, irq_mask_reg, irq_clear_reg} = 28'h0;
      fifo_level_select_reg = 6'h12;
      fails = 0;
      checks_done = 0;
      repeat (20) @(negedge clock);
      rst_n = 1'b1;
      repeat (2) @(negedge clock);
      s_reset();
      s_holding();
      s_fifo();
      s_infrared();
      s_loop();
      s_false_start();
      s_frame_err();
      end_sim();
   end
endmodule
`default_nettype wire

// *** serial_port_defs.svh ***
// constants for the asynchronous serial port with infrared coder
// assumes inclusion by the serial port core
`ifndef SERIAL_PORT_DEFS_SVH
`define SERIAL_PORT_DEFS_SVH

// line control bit positions
`define LCR_BRK          0
`define LCR_PEN          1
`define LCR_EPS          2
`define LCR_STP2         3
`define LCR_FEN          4
`define LCR_WLEN_LO      5
`define LCR_WLEN_HI      6
`define LCR_SPS          7
`define LCR_RESET        8'h00

// interrupt bit positions
`define IRQ_RX           4
`define IRQ_TX           5
`define IRQ_RT           6
`define IRQ_FE           7
`define IRQ_PE           8
`define IRQ_BE           9
`define IRQ_OE           10
`define IRQ_W            11

// received word layout
`define WORD_FE          8
`define WORD_PE          9
`define WORD_BE          10
`define WORD_OE          11
`define WORD_W           12

// status bit positions
`define RSR_FE           0
`define RSR_PE           1
`define RSR_BE           2
`define RSR_OE           3

// fifo and level select
`define FIFO_DEPTH       16
`define LEVEL_RESET      6'h12

// bit timing in 16x ticks
`define TICKS_PER_BIT    16
`define START_CHECK_TICK 4'h7
`define LAST_TICK        4'hf
`define IR_PULSE_TICKS   4'h3
`define IR_LP_PULSE      2'h3
`define IR_HOLD_TICKS    4'hc
`define RX_TIMEOUT_BITS  32
`define RX_TIMEOUT_TICKS (`RX_TIMEOUT_BITS * `TICKS_PER_BIT)

`endif

// *** serial_port_pkg.sv ***
// types for the asynchronous serial port
// assumes serial_port_defs.svh is on the include path
package serial_port_pkg;
   typedef enum logic [2:0] {
      TX_IDLE   = 3'b000,
      TX_START  = 3'b001,
      TX_DATA   = 3'b010,
      TX_PARITY = 3'b011,
      TX_STOP1  = 3'b100,
      TX_STOP2  = 3'b101
   } tx_state_e;

   typedef enum logic [2:0] {
      RX_IDLE   = 3'b000,
      RX_START  = 3'b001,
      RX_DATA   = 3'b010,
      RX_PARITY = 3'b011,
      RX_STOP   = 3'b100
   } rx_state_e;
endpackage
